// ### logic/adc_status_control_registers.sv
// Purpose: status and control register bank of a delta-sigma converter
// Assumes: filter and calibration engines report on the system clock
// Notes: serial link runs on its own clock, crossings by toggle and sync
// Behaviour
// R1: clip flag on bad system gain; saturate span
// R2: rate bits follow held result or calibration
// R3: over-full-scale flag follows clipped result high
// R4: below-minimum flag follows clipped result low
// R5: busy flag mirrors modulator activity
// R6: ready flag sets on each new result
// R7: ready clears on start or read mid-conversion; code clears on start only once the result was read while idle
// R8: bit 7 picks 50 or 60 Hz rates
// R9: bit 6 picks unipolar or bipolar range
// R10: bit 5 picks external or internal clock
// R11: bit 4 powers reference buffers
// R12: bit 3 powers input buffers
// R13: bit 2 picks bipolar code style
// R14: single shot converts once, then powers down
// R15: continuous mode drops first three results
// R16: ready line rises at end of conversion
// R17: host times result reads from ready rising
// R18: gain bits act only with gain option
// R19: select codes map the nine registers
// R20: start and mode bits mark register access
// R21: writes to the result register are ignored
// R22: gpio direction picks pin input or drive
// R23: bit 0 of control registers reads zero; code masks it in config and gain/cal only, gpio bit 0 reads pin 0 or stored bit 0
`timescale 1ns/10ps
`include "adc_regs.svh"
module adc_status_control_registers
	import adc_pkg::*;
#(
	parameter bit HAS_PGA = 1'b1
) (
	// system clock and reset
	input  wire logic       CLK_SYS_IN,
	input  wire logic       RST_B_IN,
	// serial link
	input  wire logic       SCLK_IN,
	input  wire logic       CS_B_IN,
	input  wire logic       DIN_IN,
	output logic            RDY_DOUT_OUT,
	output logic            RDY_DOUT_OE_B_OUT,
	// general purpose pins
	input  wire logic [3:0] GPIO_IN,
	output logic      [3:0] GPIO_OUT,
	output logic      [3:0] GPIO_OE_B_OUT,
	// converter reports
	input  wire conv_t      CONV_IN,
	input  wire cal_t       CAL_IN,
	input  wire logic       MOD_BUSY_IN,
	// analog and filter controls
	output logic            MAINS_50HZ_OUT,
	output logic            UNIPOLAR_OUT,
	output logic            EXT_CLK_SEL_OUT,
	output logic            REF_BUF_EN_OUT,
	output logic            IN_BUF_EN_OUT,
	output logic            TWOS_COMP_OUT,
	output logic            SINGLE_SHOT_OUT,
	output logic            POWER_DOWN_OUT,
	output logic      [2:0] DIGITAL_GAIN_OUT,
	output logic      [3:0] CAL_SKIP_OUT
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	frm_t        frm_q;
	frm_t        frm_d;
	lnk_t        lnk_q;
	lnk_t        lnk_d;
	sys_t        sys_q;
	sys_t        sys_d;
	logic        frm_rst_b;
	logic [5:0]  xfer_len;
	logic        rd_ev;
	logic        wr_ev;
	logic        done_ev;
	logic [7:0]  status_byte;
	logic [3:0]  pin_value_bits;
	logic [23:0] pick_word;

	// frame logic restarts on every chip select high
	assign frm_rst_b = RST_B_IN & ~CS_B_IN;

	// ------------------------------------------------------------
	// link clock domain
	// ------------------------------------------------------------

	// byte registers shift 8 bits, coefficient words 24
	always_comb begin
		if (lnk_q.register_pick_field >= `PICK_RESULT &&
		    lnk_q.register_pick_field <= `PICK_SELF_SPAN) begin
			xfer_len = `WORD_BITS; // see R19
		end else begin
			xfer_len = `BYTE_BITS;
		end
	end

	// frame sequencer: command byte, then payload
	always_comb begin
		frm_d = frm_q;
		case (frm_q.phase)
			PH_CMD: begin
				frm_d.cmd = {frm_q.cmd[6:0], DIN_IN};
				frm_d.cnt = frm_q.cnt + 6'h01;
				if (frm_q.cnt == `CMD_LAST_BIT) begin
					frm_d.cnt = 6'h00;
					// start=1, mode=1, bit 5 clear means register access
					if (frm_q.cmd[6] & frm_q.cmd[5] & ~frm_q.cmd[4]) begin
						frm_d.phase = PH_DATA; // see R20
						frm_d.rd    = (DIN_IN == `DIR_READ);
					end else begin
						frm_d.phase = PH_DONE;
					end
				end
			end
			PH_DATA: begin
				frm_d.cnt = frm_q.cnt + 6'h01;
				if (frm_q.cnt == xfer_len - 6'h01) begin
					frm_d.phase = PH_DONE;
				end
			end
			PH_DONE: begin
				frm_d.cnt = frm_q.cnt;
			end
			default: begin
				frm_d.phase = PH_DONE;
			end
		endcase
	end

	// link data path and crossing toggles
	always_comb begin
		lnk_d = lnk_q;
		// select is known after seven bits: fetch early so the word is ready
		if (frm_q.phase == PH_CMD && frm_q.cnt == `CMD_PICK_BIT) begin
			lnk_d.register_pick_field = {frm_q.cmd[2:0], DIN_IN};
			if (frm_q.cmd[5] & frm_q.cmd[4] & ~frm_q.cmd[3]) begin
				lnk_d.rd_tgl = ~lnk_q.rd_tgl;
			end
		end
		// read word is quiet by now; result updates timed away by host, see R17
		if (frm_q.phase == PH_CMD && frm_q.cnt == `CMD_LAST_BIT &&
		    DIN_IN == `DIR_READ) begin
			lnk_d.shift   = sys_q.read_word;
			lnk_d.out_bit = sys_q.read_word[23];
		end
		if (frm_q.phase == PH_DATA) begin
			if (frm_q.rd) begin
				lnk_d.out_bit = lnk_q.shift[22];
				lnk_d.shift   = {lnk_q.shift[22:0], 1'b0};
				if (frm_q.cnt == xfer_len - 6'h01) begin
					lnk_d.done_tgl = ~lnk_q.done_tgl;
				end
			end else begin
				lnk_d.wdata = {lnk_q.wdata[22:0], DIN_IN};
				if (frm_q.cnt == xfer_len - 6'h01) begin
					lnk_d.wr_tgl = ~lnk_q.wr_tgl;
				end
			end
		end
	end

	// frame registers
	always_ff @(posedge SCLK_IN or negedge frm_rst_b) begin
		if (!frm_rst_b) begin
			frm_q <= '0;
		end else begin
			frm_q <= frm_d;
		end
	end

	// toggles must survive chip select, so only system reset clears them
	always_ff @(posedge SCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// ------------------------------------------------------------
	// system clock domain
	// ------------------------------------------------------------

	// events from synchronised toggles
	assign rd_ev   = sys_q.rd_s[1] ^ sys_q.rd_s[2];
	assign wr_ev   = sys_q.wr_s[1] ^ sys_q.wr_s[2];
	assign done_ev = sys_q.done_s[1] ^ sys_q.done_s[2];

	// readback views
	always_comb begin
		status_byte = {sys_q.system_gain_clip_flag, sys_q.rate,
		               sys_q.over_full_scale_flag, sys_q.below_minimum_flag,
		               sys_q.modulator_busy_flag, sys_q.result_ready_flag};
		// inputs show the pin, outputs the stored bit
		pin_value_bits = (sys_q.gpio_control[7:4] & sys_q.gpio_control[3:0]) |
		                 (~sys_q.gpio_control[7:4] & sys_q.pin_b); // see R22
		case (lnk_q.register_pick_field)
			`PICK_STATUS:    pick_word = {status_byte, 16'h0000};
			`PICK_CONFIG:    pick_word = {sys_q.config_one & `KEEP_MASK, 16'h0000};
			`PICK_GPIO:      pick_word = {sys_q.gpio_control[7:4], pin_value_bits, 16'h0000};
			`PICK_GAINCAL:   pick_word = {sys_q.gain_cal_control & `KEEP_MASK, 16'h0000};
			`PICK_RESULT:    pick_word = sys_q.conversion_result; // see R19
			`PICK_SYS_ZERO:  pick_word = sys_q.system_offset_coef;
			`PICK_SYS_SPAN:  pick_word = sys_q.system_span_coef;
			`PICK_SELF_ZERO: pick_word = sys_q.self_zero_coef;
			`PICK_SELF_SPAN: pick_word = sys_q.self_span_coef;
			default:         pick_word = 24'h000000;
		endcase
	end

	// register bank next state
	always_comb begin
		sys_d = sys_q;
		// two-flop synchronisers; first stage feeds only the second
		sys_d.cs_s   = {sys_q.cs_s[0], CS_B_IN};
		sys_d.drv_s  = {sys_q.drv_s[0], frm_q.rd};
		sys_d.dout_s = {sys_q.dout_s[0], lnk_q.out_bit};
		sys_d.rd_s   = {sys_q.rd_s[1:0], lnk_q.rd_tgl};
		sys_d.wr_s   = {sys_q.wr_s[1:0], lnk_q.wr_tgl};
		sys_d.done_s = {sys_q.done_s[1:0], lnk_q.done_tgl};
		sys_d.pin_a  = GPIO_IN;
		sys_d.pin_b  = sys_q.pin_a;
		sys_d.modulator_busy_flag = MOD_BUSY_IN; // see R5
		if (rd_ev) begin
			sys_d.read_word = pick_word;
		end
		// software writes; reserved bit 0 is dropped in config and gain/cal, kept in gpio
		if (wr_ev) begin
			case (lnk_q.register_pick_field)
				`PICK_CONFIG:    sys_d.config_one = lnk_q.wdata[7:0] & `KEEP_MASK; // see R23
				`PICK_GPIO:      sys_d.gpio_control = lnk_q.wdata[7:0];
				`PICK_GAINCAL:   sys_d.gain_cal_control = lnk_q.wdata[7:0] & `KEEP_MASK;
				`PICK_SYS_ZERO:  sys_d.system_offset_coef = lnk_q.wdata;
				`PICK_SYS_SPAN:  sys_d.system_span_coef = lnk_q.wdata;
				`PICK_SELF_ZERO: sys_d.self_zero_coef = lnk_q.wdata;
				`PICK_SELF_SPAN: sys_d.self_span_coef = lnk_q.wdata;
				default:         sys_d.read_seen = sys_q.read_seen; // see R21
			endcase
		end
		// read of the result finished: clear now if a conversion runs
		if (done_ev && lnk_q.register_pick_field == `PICK_RESULT) begin
			if (sys_q.modulator_busy_flag) begin
				sys_d.result_ready_flag = 1'b0; // see R7
			end else begin
				sys_d.read_seen = 1'b1;
			end
		end
		// conversion start
		if (CONV_IN.start) begin
			sys_d.power_down = 1'b0;
			if (sys_q.config_one[`CFG_SINGLE]) begin
				sys_d.latent = 2'h0;
			end else begin
				sys_d.latent = `LATENT_RESULTS; // see R15
			end
			if (sys_q.read_seen) begin
				sys_d.result_ready_flag = 1'b0; // see R7
				sys_d.read_seen = 1'b0;
			end
		end
		// conversion end; a set wins over any clear above
		if (CONV_IN.done) begin
			if (sys_q.latent != 2'h0) begin
				sys_d.latent = sys_q.latent - 2'h1; // see R15
			end else begin
				sys_d.conversion_result    = CONV_IN.value;
				sys_d.rate                 = CONV_IN.rate;  // see R2
				sys_d.over_full_scale_flag = CONV_IN.over;  // see R3
				sys_d.below_minimum_flag   = CONV_IN.under; // see R4
				sys_d.result_ready_flag    = 1'b1;          // see R6
				sys_d.read_seen            = 1'b0;
				if (sys_q.config_one[`CFG_SINGLE]) begin
					sys_d.power_down = 1'b1; // see R14
				end
			end
		end
		// calibration results; gain coefficients saturate at the maximum
		if (CAL_IN.wr) begin
			sys_d.rate = CAL_IN.rate; // see R2
			case (CAL_IN.target)
				`CAL_SYS_ZERO: sys_d.system_offset_coef = CAL_IN.value;
				`CAL_SYS_SPAN: begin
					sys_d.system_gain_clip_flag = CAL_IN.ovf; // see R1
					sys_d.system_span_coef = CAL_IN.ovf ? `SPAN_MAX : CAL_IN.value;
				end
				`CAL_SELF_ZERO: sys_d.self_zero_coef = CAL_IN.value;
				default: sys_d.self_span_coef = CAL_IN.ovf ? `SPAN_MAX : CAL_IN.value; // see R1
			endcase
		end
		// derived outputs, one cycle behind the registers
		sys_d.twos = ~sys_q.config_one[`CFG_UNIPOLAR] &
		             ~sys_q.config_one[`CFG_FORMAT]; // see R13
		sys_d.digital_gain_field = HAS_PGA ? sys_q.gain_cal_control[7:5] : 3'h0; // see R18
		sys_d.gpio_out  = sys_q.gpio_control[3:0];   // see R22
		sys_d.gpio_oe_b = ~sys_q.gpio_control[7:4];
		// ready level when idle, shifted bit during a read
		sys_d.dout_oe_b = sys_q.cs_s[1];
		sys_d.dout = (sys_q.drv_s[1]) ? sys_q.dout_s[1] : sys_q.result_ready_flag; // see R16
	end

	// system registers
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			sys_q                  <= '0;
			sys_q.cs_s             <= 2'b11;
			sys_q.config_one       <= `RST_CONFIG;
			sys_q.gpio_control     <= `RST_GPIO;
			sys_q.gain_cal_control <= `RST_GAINCAL;
			sys_q.twos             <= 1'b1;
			sys_q.dout_oe_b        <= 1'b1;
			sys_q.gpio_out         <= 4'hF;
			sys_q.gpio_oe_b        <= 4'hF;
		end else begin
			sys_q <= sys_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign RDY_DOUT_OUT      = sys_q.dout;
	assign RDY_DOUT_OE_B_OUT = sys_q.dout_oe_b;
	assign GPIO_OUT          = sys_q.gpio_out;
	assign GPIO_OE_B_OUT     = sys_q.gpio_oe_b;
	assign MAINS_50HZ_OUT    = sys_q.config_one[`CFG_MAINS];    // see R8
	assign UNIPOLAR_OUT      = sys_q.config_one[`CFG_UNIPOLAR]; // see R9
	assign EXT_CLK_SEL_OUT   = sys_q.config_one[`CFG_CLOCK_SOURCE_SELECT];   // see R10
	assign REF_BUF_EN_OUT    = sys_q.config_one[`CFG_REFERENCE_BUFFER_ENABLE];   // see R11
	assign IN_BUF_EN_OUT     = sys_q.config_one[`CFG_INBUF];    // see R12
	assign TWOS_COMP_OUT     = sys_q.twos;
	assign SINGLE_SHOT_OUT   = sys_q.config_one[`CFG_SINGLE];   // see R14
	assign POWER_DOWN_OUT    = sys_q.power_down;
	assign DIGITAL_GAIN_OUT  = sys_q.digital_gain_field;
	assign CAL_SKIP_OUT      = sys_q.gain_cal_control[4:1];

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_valid_done;
		CONV_IN.done && sys_q.latent == 2'h0;
	endsequence

	sequence s_read_in_conv;
		done_ev && lnk_q.register_pick_field == `PICK_RESULT &&
		sys_q.modulator_busy_flag && !CONV_IN.done;
	endsequence

	property p_rdy_set;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		s_valid_done |=> sys_q.result_ready_flag ##2 RDY_DOUT_OUT || sys_q.drv_s[1];
	endproperty
	a_rdy_set: assert property (p_rdy_set) else $error("ready not set"); // see R6

	property p_rdy_read_clear;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		s_read_in_conv |=> !sys_q.result_ready_flag;
	endproperty
	a_rdy_read_clear: assert property (p_rdy_read_clear) else $error("ready kept"); // see R7

	property p_over;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		s_valid_done |=> sys_q.over_full_scale_flag == $past(CONV_IN.over) &&
		                 sys_q.below_minimum_flag == $past(CONV_IN.under);
	endproperty
	a_over: assert property (p_over) else $error("range flags wrong"); // see R3

	property p_rate;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		(s_valid_done and !CAL_IN.wr) |=> sys_q.rate == $past(CONV_IN.rate);
	endproperty
	a_rate: assert property (p_rate) else $error("rate bits wrong"); // see R2

	property p_busy;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		MOD_BUSY_IN [*2] |=> sys_q.modulator_busy_flag && $past(sys_q.modulator_busy_flag);
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag wrong"); // see R5

	property p_power_down;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		(s_valid_done and (SINGLE_SHOT_OUT && !CONV_IN.start)) |=> POWER_DOWN_OUT;
	endproperty
	a_power_down: assert property (p_power_down) else $error("no power down"); // see R14

	property p_latent;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		CONV_IN.start && !SINGLE_SHOT_OUT && !CONV_IN.done |=> sys_q.latent == 2'h3;
	endproperty
	a_latent: assert property (p_latent) else $error("latency count wrong"); // see R15

	property p_clip;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		CAL_IN.wr && CAL_IN.target == `CAL_SYS_SPAN && CAL_IN.ovf |=>
		sys_q.system_gain_clip_flag && sys_q.system_span_coef == 24'hFFFFFF;
	endproperty
	a_clip: assert property (p_clip) else $error("gain clip missed"); // see R1

	property p_result_ro;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		wr_ev && lnk_q.register_pick_field == `PICK_RESULT && !CONV_IN.done |=>
		$stable(sys_q.conversion_result);
	endproperty
	a_result_ro: assert property (p_result_ro) else $error("result written"); // see R21

	property p_gpio_dir;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		wr_ev && lnk_q.register_pick_field == `PICK_GPIO |=>
		##1 GPIO_OE_B_OUT == ~$past(lnk_q.wdata[7:4], 2);
	endproperty
	a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong"); // see R22

	property p_reserved;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		rd_ev && lnk_q.register_pick_field == `PICK_CONFIG |=> sys_q.read_word[16] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set"); // see R23

	property p_twos;
		@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		UNIPOLAR_OUT [*2] |-> !TWOS_COMP_OUT;
	endproperty
	a_twos: assert property (p_twos) else $error("code style wrong"); // see R13

endmodule // adc_status_control_registers

// ### pkg/adc_regs.svh
// Purpose: register selects, field positions, reset values and counts
// Assumes: included by bare name, before the design modules
// Notes: constants only, no logic
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define PICK_STATUS     4'h0
`define PICK_CONFIG     4'h1
`define PICK_GPIO       4'h2
`define PICK_GAINCAL    4'h3
`define PICK_RESULT     4'h4
`define PICK_SYS_ZERO   4'h5
`define PICK_SYS_SPAN   4'h6
`define PICK_SELF_ZERO  4'h7
`define PICK_SELF_SPAN  4'h8

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define RST_CONFIG      8'h02
`define RST_GPIO        8'h0F
`define RST_GAINCAL     8'h1E
`define KEEP_MASK       8'hFE
`define SPAN_MAX        24'hFFFFFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_MAINS       7
`define CFG_UNIPOLAR    6
`define CFG_CLOCK_SOURCE_SELECT      5
`define CFG_REFERENCE_BUFFER_ENABLE      4
`define CFG_INBUF       3
`define CFG_FORMAT      2
`define CFG_SINGLE      1

// ----------------------------------------------------------------
// link framing and counts
// ----------------------------------------------------------------
`define CMD_PICK_BIT    6'h06
`define CMD_LAST_BIT    6'h07
`define BYTE_BITS       6'h08
`define WORD_BITS       6'h18
`define DIR_READ        1'b1
`define LATENT_RESULTS  2'h3
`define CAL_SYS_ZERO    2'h0
`define CAL_SYS_SPAN    2'h1
`define CAL_SELF_ZERO   2'h2
`define CAL_SELF_SPAN   2'h3

`endif

// ### pkg/adc_pkg.sv
// Purpose: types shared by the converter register bank
// Assumes: constants live in adc_regs.svh
// Notes: two state structs on the link clock, one on the system clock
package adc_pkg;

	// frame phase on the link clock
	typedef enum logic [1:0] {
		PH_CMD  = 2'b00,
		PH_DATA = 2'b01,
		PH_DONE = 2'b10
	} phase_t;

	// end-of-conversion report from the filter
	typedef struct packed {
		logic        start;
		logic        done;
		logic [2:0]  rate;
		logic        over;
		logic        under;
		logic [23:0] value;
	} conv_t;

	// calibration coefficient report
	typedef struct packed {
		logic        wr;
		logic [1:0]  target;
		logic        ovf;
		logic [2:0]  rate;
		logic [23:0] value;
	} cal_t;

	// frame state, cleared whenever chip select is high
	typedef struct packed {
		phase_t      phase;
		logic [5:0]  cnt;
		logic [7:0]  cmd;
		logic        rd;
	} frm_t;

	// link state that outlives a frame
	typedef struct packed {
		logic        rd_tgl;
		logic        wr_tgl;
		logic        done_tgl;
		logic [3:0]  register_pick_field;
		logic [23:0] shift;
		logic [23:0] wdata;
		logic        out_bit;
	} lnk_t;

	// system clock state
	typedef struct packed {
		logic [1:0]  cs_s;
		logic [1:0]  drv_s;
		logic [1:0]  dout_s;
		logic [2:0]  rd_s;
		logic [2:0]  wr_s;
		logic [2:0]  done_s;
		logic [3:0]  pin_a;
		logic [3:0]  pin_b;
		logic        system_gain_clip_flag;
		logic [2:0]  rate;
		logic        over_full_scale_flag;
		logic        below_minimum_flag;
		logic        modulator_busy_flag;
		logic        result_ready_flag;
		logic        read_seen;
		logic [7:0]  config_one;
		logic [7:0]  gpio_control;
		logic [7:0]  gain_cal_control;
		logic [23:0] conversion_result;
		logic [23:0] system_offset_coef;
		logic [23:0] system_span_coef;
		logic [23:0] self_zero_coef;
		logic [23:0] self_span_coef;
		logic [23:0] read_word;
		logic [1:0]  latent;
		logic        power_down;
		logic        twos;
		logic [2:0]  digital_gain_field;
		logic        dout;
		logic        dout_oe_b;
		logic [3:0]  gpio_out;
		logic [3:0]  gpio_oe_b;
	} sys_t;

endpackage

// ### sim/adc_link_host.sv
// Purpose: host side of the serial register link
// Assumes: link period 32 ns, unrelated to the system clock
// Notes: clock parked low and data idles inverted between frames
`timescale 1ns/10ps
module adc_link_host (
	// serial link
	output logic      SCLK_OUT,
	output logic      CS_B_OUT,
	output logic      DIN_OUT,
	input  wire logic DOUT_IN
);
	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	initial begin
		SCLK_OUT = 1'b0;
		CS_B_OUT = 1'b1;
		DIN_OUT  = 1'b0;
	end

	// ----------------------------------------------------------------
	// one access per chip-select period, msb first
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
		output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, 24'(wd << (24 - n))};
		rd = '0;
		CS_B_OUT = 1'b0;
		#27;
		// data moves on the falling edge, so it is stable at each rising edge
		for (int i = 0; i < 8 + n; i++) begin
			DIN_OUT = sh[31 - i];
			#16 SCLK_OUT = 1'b1;
			if (i >= 8)
				rd = {rd[22:0], DOUT_IN};
			#16 SCLK_OUT = 1'b0;
		end
		#16 CS_B_OUT = 1'b1;
		DIN_OUT = ~DIN_OUT;
		#61;
	endtask

	// chip select held low with the clock still, to watch ready
	task automatic park(input logic low);
		#1 CS_B_OUT = ~low;
	endtask
endmodule // adc_link_host

// ### sim/test_adc_status_control_registers.sv
// Purpose: self-checking bench of the converter register bank
// Assumes: host model drives the link, bench drives converter reports
// Notes: expectations come from the register map, never from the design
`timescale 1ns/10ps
module test_adc_status_control_registers
	import adc_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk, rst_b, sclk, cs_b, din, dout, oe_b, busy;
	logic        mains, unip, extc, refb, inb, twos, single, pdown;
	logic [2:0]  digital_gain_field;
	logic [3:0]  gin, gout, goe_b, skip;
	conv_t       conv;
	cal_t        cal;
	wire         rdy_wire;
	integer      seed, n_mismatch, n_compared;
	logic [23:0] v, r;
	logic [7:0]  d;
	// a released line floats, so a missed drive never passes as data
	assign rdy_wire = oe_b ? 1'bz : dout;

	adc_status_control_registers uut (
		.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SCLK_IN(sclk), .CS_B_IN(cs_b),
		.DIN_IN(din), .RDY_DOUT_OUT(dout), .RDY_DOUT_OE_B_OUT(oe_b),
		.GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE_B_OUT(goe_b),
		.CONV_IN(conv), .CAL_IN(cal), .MOD_BUSY_IN(busy),
		.MAINS_50HZ_OUT(mains), .UNIPOLAR_OUT(unip), .EXT_CLK_SEL_OUT(extc),
		.REF_BUF_EN_OUT(refb), .IN_BUF_EN_OUT(inb), .TWOS_COMP_OUT(twos),
		.SINGLE_SHOT_OUT(single), .POWER_DOWN_OUT(pdown),
		.DIGITAL_GAIN_OUT(digital_gain_field), .CAL_SKIP_OUT(skip));
	adc_link_host host (.SCLK_OUT(sclk), .CS_B_OUT(cs_b), .DIN_OUT(din), .DOUT_IN(rdy_wire));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// selects 4..8 carry a word, the rest a byte; rdn 1 reads
	task automatic acc(input logic [3:0] sel, input logic rdn, input logic [23:0] wd);
		host.xfer({3'b110, sel, rdn}, (sel > 4'h3 && sel < 4'h9) ? 24 : 8, wd, r);
		repeat (4) @(posedge clk);
	endtask
	task automatic ev(input logic st, dn, input logic [23:0] val, input logic [2:0] rt,
		input logic ov, un);
		@(posedge clk);
		conv <= '{st, dn, rt, ov, un, val};
		@(posedge clk);
		conv <= '0;
		repeat (3) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		complete_run();
	end

	// main sequence
	initial begin
		seed = 32'h7E82;
		n_mismatch = 0;
		n_compared = 0;
		rst_b = 1'b0;
		busy = 1'b0;
		conv = '0;
		cal = '0;
		gin = 4'hA;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		acc(4'h0, 1'b1, 24'h0);
		check(r, 24'h00);
		acc(4'h1, 1'b1, 24'h0);
		check(r, 24'h02);
		acc(4'h3, 1'b1, 24'h0);
		check(r, 24'h1E);
		check({single, twos, skip, goe_b, gout}, 14'h3FFF);
		$display("reset test done");
		// corners first, then random control bytes
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
			acc(4'h1, 1'b0, {16'h0, d});
			acc(4'h1, 1'b1, 24'h0);
			check(r, {16'h0, d & 8'hFE});
			check({mains, unip, extc, refb, inb, twos, single},
				{d[7:3], ~d[6] & ~d[2], d[1]});
		end
		acc(4'h1, 1'b0, 24'h02);
		$display("control test done");
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			@(posedge clk);
			gin <= 4'($random(seed));
			acc(4'h3, 1'b0, {16'h0, d});
			acc(4'h3, 1'b1, 24'h0);
			check({r[7:0], digital_gain_field, skip}, {d & 8'hFE, d[7:5], d[4:1]});
			acc(4'h2, 1'b0, {16'h0, d});
			acc(4'h2, 1'b1, 24'h0);
			check(r, {16'h0, d[7:4], (d[7:4] & d[3:0]) | (~d[7:4] & gin)});
			check({goe_b, gout}, {~d[7:4], d[3:0]});
		end
		// coefficient words, the read-only result and an unused select
		for (int s = 5; s < 9; s++) begin
			v = 24'($random(seed));
			acc(4'(s), 1'b0, v);
			acc(4'(s), 1'b1, 24'h0);
			check(r, v);
		end
		acc(4'h4, 1'b0, 24'hA5A5A5);
		acc(4'h4, 1'b1, 24'h0);
		check(r, 24'h0);
		acc(4'h9, 1'b1, 24'h0);
		check(r, 24'h0);
		$display("map test done");
		// single shot: clipped high, clipped low, in range
		for (int i = 0; i < 3; i++) begin
			v = 24'($random(seed));
			d[2:0] = 3'($random(seed));
			@(posedge clk);
			busy <= 1'b1;
			ev(1'b1, 1'b0, 24'h0, 3'h0, 1'b0, 1'b0);
			acc(4'h0, 1'b1, 24'h0);
			check(r[1:0], 2'b10);
			ev(1'b0, 1'b1, v, d[2:0], i == 0, i == 1);
			busy <= 1'b0;
			acc(4'h0, 1'b1, 24'h0);
			check(r, {16'h0, 1'b0, d[2:0], i == 0, i == 1, 2'b01});
			check(pdown, 1'b1);
			acc(4'h4, 1'b1, 24'h0);
			check(r, v);
		end
		// unread result survives a start; a read mid-conversion clears it
		ev(1'b1, 1'b0, 24'h0, 3'h0, 1'b0, 1'b0);
		ev(1'b0, 1'b1, 24'h123456, 3'h5, 1'b0, 1'b0);
		busy <= 1'b1;
		ev(1'b1, 1'b0, 24'h0, 3'h0, 1'b0, 1'b0);
		acc(4'h0, 1'b1, 24'h0);
		check(r[1:0], 2'b11);
		acc(4'h4, 1'b1, 24'h0);
		acc(4'h0, 1'b1, 24'h0);
		check(r[1:0], 2'b10);
		$display("conversion test done");
		// continuous: three latent results, the ready line rises on the fourth
		acc(4'h1, 1'b0, 24'h00);
		host.park(1'b1);
		ev(1'b1, 1'b0, 24'h0, 3'h0, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			v = 24'($random(seed));
			ev(1'b0, 1'b1, v, 3'h2, 1'b0, 1'b0);
			check(rdy_wire, i == 3);
		end
		host.park(1'b0);
		acc(4'h4, 1'b1, 24'h0);
		check(r, v);
		$display("continuous test done");
		// system span calibration out of range, then back in range
		for (int i = 0; i < 2; i++) begin
			v = 24'($random(seed));
			@(posedge clk);
			cal <= '{1'b1, 2'h1, i == 0, 3'h6, v};
			@(posedge clk);
			cal <= '0;
			acc(4'h0, 1'b1, 24'h0);
			check(r[7:4], {i == 0, 3'h6});
			acc(4'h6, 1'b1, 24'h0);
			check(r, (i == 0) ? 24'hFFFFFF : v);
		end
		$display("calibration test done");
		complete_run();
	end
endmodule // test_adc_status_control_registers
